// ===== bench/rfcsl_host.sv
// Purpose : host model driving the three select pins of the loader
// Assumes : push-pull pins, changed just after a rising hclk edge
// Notes   : minimum phase times carry a margin for the pin synchronisers
module rfcsl_host #(
  parameter int unsigned GAP_WAIT = 50
) (
  input  wire logic hclk,
  output logic      bit0,
  output logic      sclk,
  output logic      sdata
);
  // idle level: both serial lines high, full logic levels only
  initial begin
    bit0  = 1'b1;
    sclk  = 1'b1;
    sdata = 1'b1;
  end

  // wait a number of clock edges
  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // static three-pin channel code, bit2 on the data pin
  task automatic set_par(input logic [2:0] v);
    @(posedge hclk);
    {sdata, sclk, bit0} <= v;
  endtask

  // one packet; slow stretches each phase, high_cyc sets the clock-high time
  task automatic send(input logic [7:0] v, input int slow, input int high_cyc);
    hold(GAP_WAIT + 20);
    sdata <= 1'b0;
    hold(rfcsl_pkg::START_HOLD_CYC + 20 + slow);
    for (int i = 0; i < 8; i++) begin
      sclk  <= 1'b0;
      sdata <= v[i];
      hold(rfcsl_pkg::CLOCK_LOW_CYC + 10 + slow);
      sclk <= 1'b1;
      hold(high_cyc);
    end
    sdata <= 1'b1;
    hold(rfcsl_pkg::LATCH_HOLD_CYC + 20 + slow);
  endtask
endmodule

// ===== bench/rfcsl_top_test.sv
// Purpose : self-checking bench for the channel select loader
// Assumes : shortened settle and gap counts set through parameters
// Notes   : registers reached over AHB-Lite, pins driven by the host model
module rfcsl_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CHG  = 100;
  localparam int unsigned TURN = 200;
  localparam int unsigned GAP  = 50;
  logic        hclk, hresetn, hsel, hwrite, mode_serial;
  logic        hreadyout, hresp, chan_ready_q, bit0, sclk, sdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  chan_q;
  logic [31:0] haddr, hwdata, hrdata, hrdata_s, rd, r, seed;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  rfcsl_top #(.CHG_CYCLES(CHG), .TURN_CYCLES(TURN), .GAP_CYCLES(GAP)) rfcsl_top_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mode_serial,
    .chan_sel_bit0(bit0), .chan_sel_bit1_serial_clock(sclk),
    .chan_sel_bit2_serial_data(sdata), .chan_q, .chan_ready_q
  );
  rfcsl_host #(.GAP_WAIT(GAP)) rfcsl_host_inst (.hclk, .bit0, .sclk, .sdata);

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // read data as it stood at each rising edge
  always @(posedge hclk) hrdata_s <= hrdata;

  // cut a hang short
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_errors++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // out-of-range serial values land on the fail channel
  function automatic logic [7:0] exp_chan(input logic [7:0] c);
    return (c > rfcsl_pkg::CHAN_MAX) ? rfcsl_pkg::CHAN_FAIL : c;
  endfunction

  // status word with ready set
  function automatic logic [31:0] exp_stat(input logic [7:0] c, input logic err, ser);
    return {16'h0000, c, 5'h00, err, ser, 1'b1};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%08h exp=%08h", $time, got, exp);
    end
  endtask

  // single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1 rd = hrdata_s;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // one serial load, then channel and ready checks
  task automatic load(input logic [7:0] c, input logic short_high);
    int s;
    s = int'(rnd() & 32'h0000_003F);
    rfcsl_host_inst.send(c, s, short_high ? 400 : rfcsl_pkg::CLOCK_HIGH_CYC + 10 + s);
    repeat (10) @(posedge hclk);
    chk({24'h0, chan_q}, {24'h0, short_high ? rfcsl_pkg::CHAN_FAIL : exp_chan(c)});
    repeat (CHG + 15) @(posedge hclk);
    chk({31'h0, chan_ready_q}, 32'h1);
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, mode_serial, htrans} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'h2;
    seed  = 32'h3347F56F;
    repeat (2) @(posedge hclk);
    chk({24'h0, chan_q}, {24'h0, rfcsl_pkg::CHAN_DEFAULT});
    chk({31'h0, chan_ready_q}, 32'h0);
    hresetn <= 1'b1;
    ahb(1'b0, rfcsl_pkg::REG_CONTROL, 32'h0);
    chk(rd, rfcsl_pkg::CONTROL_RESET);
    ahb(1'b1, 12'h00C, 32'hFFFFFFFF);
    ahb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    r = rnd();
    ahb(1'b1, rfcsl_pkg::REG_CONTROL, r);
    ahb(1'b0, rfcsl_pkg::REG_CONTROL, 32'h0);
    chk(rd, {31'h0, r[0]});
    ahb(1'b1, rfcsl_pkg::REG_CONTROL, 32'h1);
    repeat (TURN + 20) @(posedge hclk);
    chk({31'h0, chan_ready_q}, 32'h1);
    // every parallel code, in an order set by the seed
    r = rnd();
    for (int i = 0; i < 8; i++) begin
      rfcsl_host_inst.set_par(i[2:0] ^ r[2:0]);
      repeat (6) @(posedge hclk);
      chk({24'h0, chan_q}, {29'h0, i[2:0] ^ r[2:0]});
      repeat (CHG + 15) @(posedge hclk);
      chk({31'h0, chan_ready_q}, 32'h1);
    end
    ahb(1'b0, rfcsl_pkg::REG_STATUS, 32'h0);
    chk(rd, exp_stat({5'h00, 3'h7 ^ r[2:0]}, 1'b0, 1'b0));
    // serial mode with the lines idle high
    rfcsl_host_inst.set_par(3'b111);
    mode_serial <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({24'h0, chan_q}, {24'h0, rfcsl_pkg::CHAN_DEFAULT});
    r = rnd();
    load(r[7:0] % 8'd101, 1'b0);
    load(8'd100, 1'b0);
    ahb(1'b0, rfcsl_pkg::REG_LOADS, 32'h0);
    chk(rd, 32'h2);
    load(8'd1 + r[15:8] % 8'd100, 1'b1);
    ahb(1'b0, rfcsl_pkg::REG_STATUS, 32'h0);
    chk(rd, exp_stat(rfcsl_pkg::CHAN_FAIL, 1'b1, 1'b1));
    load(8'd1 + r[23:16] % 8'd100, 1'b0);
    load(8'd101, 1'b0);
    conclude();
  end
endmodule

// ===== rtl/rfcsl_pkg.sv
// Purpose : constants and types for the channel select loader
// Assumes : hclk at 100 MHz
// Notes   : register map and timing counts live here
package rfcsl_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned START_HOLD_US   = 25;
  localparam int unsigned CLOCK_LOW_US    = 5;
  localparam int unsigned CLOCK_HIGH_US   = 8;
  localparam int unsigned LATCH_HOLD_US   = 5;
  localparam int unsigned GAP_MS          = 1;
  localparam int unsigned CHG_TIME_US     = 1500;
  localparam int unsigned TURN_ON_US      = 10000;
  // device-side checks use the host minimums, rounded up
  localparam int unsigned START_HOLD_CYC  = START_HOLD_US * CLK_MHZ;
  localparam int unsigned CLOCK_LOW_CYC   = CLOCK_LOW_US * CLK_MHZ;
  localparam int unsigned CLOCK_HIGH_CYC  = CLOCK_HIGH_US * CLK_MHZ;
  localparam int unsigned LATCH_HOLD_CYC  = LATCH_HOLD_US * CLK_MHZ;
  localparam int unsigned GAP_CYC         = GAP_MS * 1000 * CLK_MHZ;
  // settle times are longest times, rounded down
  localparam int unsigned CHG_CYC         = CHG_TIME_US * CLK_MHZ;
  localparam int unsigned TURN_ON_CYC     = TURN_ON_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // channel values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CHAN_MAX        = 8'h64;
  localparam logic [7:0]  CHAN_DEFAULT    = 8'h32;
  localparam logic [7:0]  CHAN_FAIL       = 8'h00;
  localparam int unsigned PACKET_BITS     = 8;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_STATUS      = 12'h000;
  localparam logic [11:0] REG_CONTROL     = 12'h004;
  localparam logic [11:0] REG_LOADS       = 12'h008;
  localparam int unsigned ST_READY        = 0;
  localparam int unsigned ST_SERIAL       = 1;
  localparam int unsigned ST_ERROR        = 2;
  localparam int unsigned ST_CHAN_LSB     = 8;
  localparam int unsigned CTL_CHECK_TIME  = 0;
  localparam logic [31:0] CONTROL_RESET   = 32'h0000_0001;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       ready;
    logic       serial;
    logic       error;
    logic [7:0] chan;
  } rfcsl_status_t;
  typedef enum logic [2:0] {
    SR_IDLE, SR_START, SR_LOW, SR_HIGH, SR_LATCH
  } rfcsl_sstate_t;
endpackage

// ===== rtl/rfcsl_top.sv
// Purpose : channel select loader: parallel pins or two-wire serial load
// Assumes : select pins and mode strap are asynchronous to hclk
// Notes   : software watches state over AHB-Lite; no interrupt logic
// ---------------------------------------------------------------
// Summary of operation
// - mode low selects parallel channel pins
// - three pins give channel 0..7, bit2 MSB
// - mode high or open selects serial
// - bit1 is serial clock, bit2 data
// - serial channel value 0 through 100
// - clock high, data low starts packet
// - eight bits, LSB first, assembled in order
// - no upper time limit on any phase
// - after eighth bit, both high latches channel
// - serial power-up channel is 50
// - failed load falls back to channel 0
// - ready again within 1.5 ms of change
// - ready within 10 ms of power
module rfcsl_top #(
  parameter int unsigned CHG_CYCLES  = rfcsl_pkg::CHG_CYC,
  parameter int unsigned TURN_CYCLES = rfcsl_pkg::TURN_ON_CYC,
  parameter int unsigned GAP_CYCLES  = rfcsl_pkg::GAP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        mode_serial,
  input  wire logic        chan_sel_bit0,
  input  wire logic        chan_sel_bit1_serial_clock,
  input  wire logic        chan_sel_bit2_serial_data,
  output logic      [7:0]  chan_q,
  output logic             chan_ready_q
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  // two flops on every external pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= {mode_serial, chan_sel_bit2_serial_data,
                     chan_sel_bit1_serial_clock, chan_sel_bit0};
      pin_sync_q <= pin_meta_q;
    end
  end
  logic mode_s, sck_s, sda_s, sb0_s;
  assign {mode_s, sda_s, sck_s, sb0_s} = pin_sync_q;
  logic sck_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sck_prev_q <= 1'b0;
    else          sck_prev_q <= sck_s;
  end
  logic sck_rise, sck_fall;
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;

  // ---------------------------------------------------------------
  // control register and phase timer
  // ---------------------------------------------------------------
  logic [31:0] control_q;
  logic        check_time;
  assign check_time = control_q[rfcsl_pkg::CTL_CHECK_TIME];
  rfcsl_pkg::rfcsl_sstate_t st_q;
  logic [31:0] phase_cnt_q;
  // counts cycles in the current phase, saturating (no upper limit)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) phase_cnt_q <= 32'h0;
    else if (sck_rise || sck_fall || st_q == rfcsl_pkg::SR_IDLE) phase_cnt_q <= 32'h0;
    else if (phase_cnt_q != 32'hFFFF_FFFF) phase_cnt_q <= phase_cnt_q + 32'h1;
  end
  function automatic logic short_phase(input logic [31:0] cnt, input int unsigned min_c,
                                       input logic en);
    short_phase = en && (cnt < min_c);
  endfunction

  // ---------------------------------------------------------------
  // serial receiver
  // ---------------------------------------------------------------
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic       load_ok, load_bad;
  logic       gap_ok;
  logic [31:0] gap_cnt_q;
  // idle time since last packet or reset, for the gap check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_cnt_q <= 32'h0;
    else if (st_q != rfcsl_pkg::SR_IDLE) gap_cnt_q <= 32'h0;
    else if (gap_cnt_q != 32'hFFFF_FFFF) gap_cnt_q <= gap_cnt_q + 32'h1;
  end
  // the gap counter clears as soon as a start is seen, so the idle time
  // is judged while still idle and held through the start phase
  logic gap_met_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_met_q <= 1'b0;
    else if (st_q == rfcsl_pkg::SR_IDLE) gap_met_q <= (gap_cnt_q >= GAP_CYCLES);
  end
  assign gap_ok = !check_time || gap_met_q;
  // packet sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= rfcsl_pkg::SR_IDLE;
      shift_q   <= 8'h00;
      bit_cnt_q <= 4'h0;
    end else if (!mode_s) begin
      st_q <= rfcsl_pkg::SR_IDLE;
    end else begin
      case (st_q)
        rfcsl_pkg::SR_IDLE: begin
          bit_cnt_q <= 4'h0;
          if (sck_s && !sda_s && sck_prev_q) st_q <= rfcsl_pkg::SR_START;
        end
        rfcsl_pkg::SR_START: begin
          if (sda_s && sck_s) st_q <= rfcsl_pkg::SR_IDLE; // start withdrawn
          else if (sck_fall) st_q <= rfcsl_pkg::SR_LOW;
        end
        rfcsl_pkg::SR_LOW: begin
          if (sck_rise) begin
            shift_q   <= {sda_s, shift_q[7:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            st_q      <= rfcsl_pkg::SR_HIGH;
          end
        end
        rfcsl_pkg::SR_HIGH: begin
          if (sck_fall) st_q <= rfcsl_pkg::SR_LOW;
          else if (bit_cnt_q == 4'(rfcsl_pkg::PACKET_BITS) && sda_s)
            st_q <= rfcsl_pkg::SR_LATCH;
        end
        rfcsl_pkg::SR_LATCH: begin
          if (load_ok || load_bad || !sda_s || !sck_s) st_q <= rfcsl_pkg::SR_IDLE;
        end
        default: st_q <= rfcsl_pkg::SR_IDLE;
      endcase
    end
  end
  // timing faults observed by the device side
  logic timing_bad;
  assign timing_bad =
      (st_q == rfcsl_pkg::SR_START && sck_fall &&
       (short_phase(phase_cnt_q, rfcsl_pkg::START_HOLD_CYC, check_time) || !gap_ok)) ||
      (st_q == rfcsl_pkg::SR_LOW && sck_rise &&
       short_phase(phase_cnt_q, rfcsl_pkg::CLOCK_LOW_CYC, check_time)) ||
      (st_q == rfcsl_pkg::SR_HIGH && sck_fall &&
       (short_phase(phase_cnt_q, rfcsl_pkg::CLOCK_HIGH_CYC, check_time) ||
        bit_cnt_q >= 4'(rfcsl_pkg::PACKET_BITS))) ||
      (st_q == rfcsl_pkg::SR_LATCH && (!sda_s || !sck_s));
  logic err_flag_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) err_flag_q <= 1'b0;
    else if (timing_bad) err_flag_q <= 1'b1;
    else if (st_q == rfcsl_pkg::SR_IDLE) err_flag_q <= 1'b0;
  end
  // both-high time of the latch phase, counted from its own entry;
  // the phase timer still holds the clock-high time there, which
  // would let a late data rise latch at once
  logic [31:0] latch_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) latch_cnt_q <= 32'h0;
    else if (st_q != rfcsl_pkg::SR_LATCH) latch_cnt_q <= 32'h0;
    else if (latch_cnt_q != 32'hFFFF_FFFF) latch_cnt_q <= latch_cnt_q + 32'h1;
  end
  logic latch_done;
  assign latch_done = st_q == rfcsl_pkg::SR_LATCH && sda_s && sck_s &&
                      !short_phase(latch_cnt_q, rfcsl_pkg::LATCH_HOLD_CYC, check_time);
  assign load_ok  = latch_done && !err_flag_q && shift_q <= rfcsl_pkg::CHAN_MAX;
  assign load_bad = timing_bad || (latch_done && (err_flag_q ||
                    shift_q > rfcsl_pkg::CHAN_MAX));

  // ---------------------------------------------------------------
  // channel selection and ready
  // ---------------------------------------------------------------
  logic [7:0] chan_d;
  logic       mode_prev_q, started_q, last_err_q;
  always_comb begin
    chan_d = chan_q;
    if (!mode_s) chan_d = {5'h00, sda_s, sck_s, sb0_s};
    else if (!started_q || !mode_prev_q) chan_d = rfcsl_pkg::CHAN_DEFAULT;
    else if (load_ok) chan_d = shift_q;
    else if (load_bad) chan_d = rfcsl_pkg::CHAN_FAIL;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_q      <= rfcsl_pkg::CHAN_DEFAULT;
      mode_prev_q <= 1'b0;
      started_q   <= 1'b0;
      last_err_q  <= 1'b0;
    end else begin
      chan_q      <= chan_d;
      mode_prev_q <= mode_s;
      started_q   <= 1'b1;
      if (load_ok) last_err_q <= 1'b0;
      else if (load_bad) last_err_q <= 1'b1;
    end
  end
  // lock timer: restarts on power-up and each channel change
  logic [31:0] lock_cnt_q;
  logic        first_lock_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt_q   <= 32'h0;
      first_lock_q <= 1'b1;
      chan_ready_q <= 1'b0;
    end else if (started_q && chan_d != chan_q) begin
      lock_cnt_q   <= 32'h0;
      chan_ready_q <= 1'b0;
    end else if (lock_cnt_q >= (first_lock_q ? TURN_CYCLES : CHG_CYCLES) - 1) begin
      chan_ready_q <= 1'b1;
      first_lock_q <= 1'b0;
    end else begin
      lock_cnt_q <= lock_cnt_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  logic        dp_valid_q, dp_write_q;
  logic [11:0] dp_addr_q;
  logic [31:0] load_count_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 12'h000;
    end else if (hready) begin
      dp_valid_q <= hsel && htrans[1];
      dp_write_q <= hwrite;
      dp_addr_q  <= haddr[11:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) control_q <= rfcsl_pkg::CONTROL_RESET;
    else if (dp_valid_q && dp_write_q && dp_addr_q == rfcsl_pkg::REG_CONTROL)
      control_q <= {31'h0, hwdata[rfcsl_pkg::CTL_CHECK_TIME]};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) load_count_q <= 32'h0;
    else if (load_ok) load_count_q <= load_count_q + 32'h1;
  end
  rfcsl_pkg::rfcsl_status_t status;
  assign status = '{ready: chan_ready_q, serial: mode_s, error: last_err_q, chan: chan_q};
  always_comb begin
    case (dp_addr_q)
      rfcsl_pkg::REG_STATUS:  hrdata = {16'h0, status.chan, 5'h00, status.error,
                                        status.serial, status.ready};
      rfcsl_pkg::REG_CONTROL: hrdata = control_q;
      rfcsl_pkg::REG_LOADS:   hrdata = load_count_q;
      default:                hrdata = 32'h0;
    endcase
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  parallel_chan_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!mode_s && $stable(pin_sync_q)) |=> chan_q == {5'h00, $past(pin_sync_q[2:0])})
    else $error("parallel channel not decoded");
  serial_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_s && !mode_prev_q) |=> chan_q == 8'h32)
    else $error("serial entry did not select default channel");
  load_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    load_ok |=> chan_q <= 8'h64 && chan_q == $past(shift_q))
    else $error("loaded channel wrong");
  load_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_s && mode_prev_q && load_bad) |=> chan_q == 8'h00)
    else $error("failed load did not fall back");
  lsb_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_s && st_q == rfcsl_pkg::SR_LOW && sck_rise) |=> shift_q[7] == $past(sda_s))
    else $error("bit not shifted in at msb end");
  start_seen_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_s && st_q == rfcsl_pkg::SR_IDLE && sck_s && sck_prev_q && !sda_s)
    |=> st_q == rfcsl_pkg::SR_START)
    else $error("start condition missed");
  ready_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (started_q && chan_d != chan_q) |=> !chan_ready_q)
    else $error("ready stayed high over channel change");
  bit_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == rfcsl_pkg::SR_LATCH |-> bit_cnt_q == 4'h8)
    else $error("latch without eight bits");
  // a latch must not complete before both lines stood high long enough
  latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (load_ok && check_time) |-> latch_cnt_q >= rfcsl_pkg::LATCH_HOLD_CYC)
    else $error("latch completed too early");
  // a short start hold must fail the load
  start_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == rfcsl_pkg::SR_START && sck_fall && check_time &&
     phase_cnt_q < rfcsl_pkg::START_HOLD_CYC) |-> load_bad)
    else $error("short start hold accepted");
  // a short clock-low phase must fail the load
  clock_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == rfcsl_pkg::SR_LOW && sck_rise && check_time &&
     phase_cnt_q < rfcsl_pkg::CLOCK_LOW_CYC) |-> load_bad)
    else $error("short clock low accepted");
  // a short clock-high phase must fail the load
  clock_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == rfcsl_pkg::SR_HIGH && sck_fall && check_time &&
     phase_cnt_q < rfcsl_pkg::CLOCK_HIGH_CYC) |-> load_bad)
    else $error("short clock high accepted");
  // a start too soon after the last packet must fail the load
  gap_check_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == rfcsl_pkg::SR_START && sck_fall && check_time && !gap_met_q)
    |-> load_bad)
    else $error("short idle gap accepted");
  // parallel mode keeps the serial receiver parked
  parallel_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !mode_s |=> st_q == rfcsl_pkg::SR_IDLE)
    else $error("serial receiver active in parallel mode");
  // each serial clock rise in the low phase takes exactly one bit
  serial_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_s && st_q == rfcsl_pkg::SR_LOW && sck_rise)
    |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1)
    else $error("serial clock rise not counted");
  // the bus never signals an error response
  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus response not okay");
endmodule
